// ===== ecsu_cfg_if.sv
`timescale 1ns/1ps
interface ecsu_cfg_if;
	logic [15:0] addr;     // CPU address under decode
	logic [3:0]  base_nib; // Register block page nibble
	logic [7:0]  ctl;      // Control register
	logic [7:0]  gp_size;  // Size and timing register
	logic [7:0]  gp_base;  // General base register
	logic        hit_a;    // First I/O window hit, enabled
	logic        hit_b;    // Second I/O window hit, enabled
	logic        hit_p;    // Program hit after priority
	logic        hit_g;    // General hit after priority

	// Owner supplies settings and reads hits
	modport owner (output addr, base_nib, ctl, gp_size, gp_base,
		input hit_a, hit_b, hit_p, hit_g);
	// Decoder turns settings into hits
	modport decoder (input addr, base_nib, ctl, gp_size, gp_base,
		output hit_a, hit_b, hit_p, hit_g);
endinterface : ecsu_cfg_if

// ===== ecsu_decode.sv
`timescale 1ns/1ps
module ecsu_decode (
	ecsu_cfg_if.decoder cfg
);
	logic in_page; // Address lies in register block page
	logic raw_p;   // Program window, enable applied
	logic raw_g;   // General window, size code applied
	logic prio_g;  // General select wins overlap

	// Pure decode, no state, so hits follow the address directly
	always_comb begin
		in_page = (cfg.addr[15:12] == cfg.base_nib); // [R07]
		cfg.hit_a = in_page && cfg.ctl[ecsu_pkg::CTL_IOA_EN] &&
			(cfg.addr[11:0] >= ecsu_pkg::IOA_LO) &&
			(cfg.addr[11:0] <= ecsu_pkg::IOA_HI); // [R07] [R08]
		cfg.hit_b = in_page && cfg.ctl[ecsu_pkg::CTL_IOB_EN] &&
			(cfg.addr[11:0] >= ecsu_pkg::IOB_LO); // [R07] [R08]
		raw_p = cfg.ctl[ecsu_pkg::CTL_PROG_EN] &&
			ecsu_pkg::prog_match(cfg.addr,
			cfg.ctl[ecsu_pkg::CTL_PSIZE_HI:ecsu_pkg::CTL_PSIZE_LO]);
			// [R10] [R11]
		raw_g = ecsu_pkg::gp_match(cfg.addr, cfg.gp_base,
			cfg.gp_size[ecsu_pkg::SZ_GP_HI:ecsu_pkg::SZ_GP_LO]);
			// [R05] [R06] [R16]
		prio_g = cfg.ctl[ecsu_pkg::CTL_PRIO];
		// Overlap: only the favoured select asserts
		cfg.hit_p = raw_p && !(raw_g && prio_g); // [R13]
		cfg.hit_g = raw_g && !(raw_p && !prio_g); // [R13]
	end
endmodule : ecsu_decode

// ===== ecsu_ext_dev.sv
`timescale 1ns/1ps
// Memory on the program select; flags a transfer cut short
module ecsu_ext_dev (
	input  wire logic sel_n, // Active-low select
	input  wire logic clk,   // System clock
	input  wire logic hold,  // E cycle being stretched
	output logic      early  // Deselected mid-stretch
);
	logic was = 1'b0; // Selected last cycle
	initial early = 1'b0;
	// Transfer closes only after the stretch has run out
	always @(posedge clk) begin
		was <= !sel_n;
		if (was && sel_n && hold) early <= 1'b1;
	end
endmodule : ecsu_ext_dev

// ===== ecsu_pkg.sv
package ecsu_pkg;
	// Register offsets on the register port
	localparam logic [15:0] OFS_STRETCH  = 16'h105C; // Stretch per select
	localparam logic [15:0] OFS_CTL      = 16'h105D; // Enables, polarity
	localparam logic [15:0] OFS_GP_BASE  = 16'h105E; // General base bits
	localparam logic [15:0] OFS_GP_SIZE  = 16'h105F; // Size and timing
	localparam logic [15:0] OFS_STATUS   = 16'h105B; // Live select state

	// Control register field positions
	localparam int CTL_IOA_EN   = 7;
	localparam int CTL_IOA_POL  = 6;
	localparam int CTL_IOB_EN   = 5;
	localparam int CTL_IOB_POL  = 4;
	localparam int CTL_PRIO     = 3;
	localparam int CTL_PROG_EN  = 2;
	localparam int CTL_PSIZE_HI = 1;
	localparam int CTL_PSIZE_LO = 0;

	// Size and timing register field positions
	localparam int SZ_IOA_TIM = 7;
	localparam int SZ_IOB_TIM = 6;
	localparam int SZ_GP_POL  = 4;
	localparam int SZ_GP_TIM  = 3;
	localparam int SZ_GP_HI   = 2;
	localparam int SZ_GP_LO   = 0;

	// Stretch register field positions (low bit of each pair)
	localparam int ST_IOA  = 6;
	localparam int ST_IOB  = 4;
	localparam int ST_GP   = 2;
	localparam int ST_PROG = 0;

	// Reset values and writable masks
	localparam logic [7:0] STRETCH_RST  = 8'h00;
	localparam logic [7:0] STRETCH_EXP  = 8'h01; // One cycle on program
	localparam logic [7:0] CTL_RST      = 8'h00;
	localparam logic [7:0] CTL_EXP      = 8'h04; // Program select on
	localparam logic [7:0] GP_BASE_RST  = 8'h00;
	localparam logic [7:0] GP_BASE_MASK = 8'hFC;
	localparam logic [7:0] GP_SIZE_RST  = 8'h07;
	localparam logic [7:0] GP_SIZE_MASK = 8'hDF;

	// Fixed windows inside the register block's 4K page
	localparam logic [11:0] IOA_LO = 12'h060;
	localparam logic [11:0] IOA_HI = 12'h7FF;
	localparam logic [11:0] IOB_LO = 12'h800;
	localparam logic [2:0]  GP_SIZE_OFF = 3'h7; // Zero size code

	// Stretch sequencer states
	typedef enum logic [3:0] {
		ECSU_IDLE    = 4'h1,
		ECSU_ACCESS  = 4'h2,
		ECSU_STRETCH = 4'h4,
		ECSU_DONE    = 4'h8
	} ecsu_state_t;

	// General window hit: only bits above the window size compare
	function automatic logic gp_match(input logic [15:0] addr,
		input logic [7:0] base, input logic [2:0] code);
		logic [15:0] m;
		m = ~(16'hFFFF >> code);
		gp_match = (code != GP_SIZE_OFF) &&
			(((addr ^ {base[7:2], 10'h000}) & m) == 16'h0000);
	endfunction : gp_match

	// Program window always ends at top of memory
	function automatic logic prog_match(input logic [15:0] addr,
		input logic [1:0] code);
		logic [15:0] m;
		m = ~(16'hFFFF >> code);
		prog_match = ((addr & m) == m);
	endfunction : prog_match
endpackage : ecsu_pkg

// ===== ecsu_props.sv
`timescale 1ns/1ps
module ecsu_props #(
	parameter int ADDR_W = 16, // CPU address width
	parameter int DATA_W = 8   // Register width
) (
	input wire logic              CLK,
	input wire logic              RST_N,
	input wire logic              CE,
	input wire logic              REG_RD,
	input wire logic              REG_WR,
	input wire logic [DATA_W-1:0] REG_RDATA,
	input wire logic [ADDR_W-1:0] CPU_ADDR,
	input wire logic              ADDR_VALID,
	input wire logic              E_TICK,
	input wire logic              IO_SELECT_A,
	input wire logic              IO_SELECT_B,
	input wire logic              PROGRAM_SELECT,
	input wire logic              GENERAL_SELECT,
	input wire logic [3:0]        SELECT_PIN_OWNED,
	input wire logic              STRETCH_HOLD,
	input wire logic [1:0]        ACCESS_STRETCH
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);
	logic [2:0] ticks; // E ticks inside one stretch
	// Cleared outside a stretch so each access counts afresh
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N)
			ticks <= 3'h0;
		else if (!STRETCH_HOLD)
			ticks <= 3'h0;
		else if (E_TICK && CE)
			ticks <= ticks + 3'h1;
	end
	a_rdata_idle: assert property (CE && !REG_RD |=> REG_RDATA == '0)
		else $error("read data left standing");
	a_prog_off_idle: assert property (
		!SELECT_PIN_OWNED[2] && !$past(SELECT_PIN_OWNED[2]) |-> PROGRAM_SELECT)
		else $error("disabled program select asserted");
	a_prog_needs_valid: assert property (
		$past(CE) && !PROGRAM_SELECT |-> $past(ADDR_VALID))
		else $error("program select without valid address");
	a_prog_top_hit: assert property (CE && ADDR_VALID
		&& CPU_ADDR[ADDR_W-1 -: 3] == 3'h7 && SELECT_PIN_OWNED[2]
		&& !SELECT_PIN_OWNED[3] && !$past(REG_WR) |=> !PROGRAM_SELECT)
		else $error("program select missed top of memory");
	a_pins_quiet: assert property (CE && !ADDR_VALID
		&& !$past(ADDR_VALID) && !$past(REG_WR)
		|=> $stable({IO_SELECT_A, IO_SELECT_B, GENERAL_SELECT}))
		else $error("select moved with no access");
	a_hold_drops: assert property (CE && !ADDR_VALID |=> !STRETCH_HOLD)
		else $error("stretch outlived the access");
	a_hold_start: assert property ($rose(STRETCH_HOLD)
		|-> $past(E_TICK) && ACCESS_STRETCH != 2'h0)
		else $error("stretch began without cause");
	a_hold_length: assert property ($fell(STRETCH_HOLD)
		&& $past(ADDR_VALID) |-> ticks == {1'b0, $past(ACCESS_STRETCH)})
		else $error("stretch length wrong");
	a_hold_short: assert property (
		STRETCH_HOLD |-> ticks < {1'b0, ACCESS_STRETCH})
		else $error("stretch overran its code");
	c_long: cover property ($fell(STRETCH_HOLD) && ACCESS_STRETCH == 2'h3);
	c_prog: cover property (!PROGRAM_SELECT);
	c_read: cover property (REG_RD ##1 REG_RDATA != '0);
endmodule : ecsu_props
bind ecsu_top ecsu_props #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_props (
	.CLK(CLK), .RST_N(RST_N), .CE(CE), .REG_RD(REG_RD), .REG_WR(REG_WR),
	.REG_RDATA(REG_RDATA), .CPU_ADDR(CPU_ADDR), .ADDR_VALID(ADDR_VALID),
	.E_TICK(E_TICK), .IO_SELECT_A(IO_SELECT_A), .IO_SELECT_B(IO_SELECT_B),
	.PROGRAM_SELECT(PROGRAM_SELECT), .GENERAL_SELECT(GENERAL_SELECT),
	.SELECT_PIN_OWNED(SELECT_PIN_OWNED), .STRETCH_HOLD(STRETCH_HOLD),
	.ACCESS_STRETCH(ACCESS_STRETCH));

// ===== ecsu_top.sv
`timescale 1ns/1ps
// Summary of operation
// [R01] First I/O select: address-valid or E-high timing
// [R02] Second I/O select: address-valid or E-high timing
// [R03] General select polarity bit: 0 low, 1 high
// [R04] General select timing: address-valid or E-high
// [R05] Three-bit general size code, 111 disables
// [R06] General size resets to 111, select off
// [R07] I/O windows x060-x7FF and x800-xFFF in page
// [R08] I/O enable bits, cleared at reset
// [R09] I/O polarity bits: 1 high, 0 low
// [R10] Program enable resets to 1 in expanded mode
// [R11] Program window size, always ends at FFFF
// [R12] Program stretch resets to one in expanded
// [R13] Priority bit picks winner on overlap
// [R14] Per-select stretch of zero to three E clocks
// [R15] Program select address-valid timing, active low
// [R16] General base compared only above window size
// [R17] Stretch codes 00..11 give 0..3 cycles
// [R18] Enabled select asserts on any matching access
// [R19] Disabled select never asserts, frees pin
// [R20] Attached device completes within stretched E cycle
module ecsu_top #(
	parameter int ADDR_W = 16, // CPU address width
	parameter int DATA_W = 8   // Register width
) (
	input  wire logic              CLK,
	input  wire logic              RST_N,
	input  wire logic              CE,
	input  wire logic              EXPANDED_MODE,
	input  wire logic [15:0]       REG_ADDR,
	input  wire logic [DATA_W-1:0] REG_WDATA,
	input  wire logic              REG_WR,
	input  wire logic              REG_RD,
	output logic      [DATA_W-1:0] REG_RDATA,
	input  wire logic [ADDR_W-1:0] CPU_ADDR,
	input  wire logic              ADDR_VALID,
	input  wire logic              E_HIGH,
	input  wire logic              E_TICK,
	input  wire logic [3:0]        REG_BLOCK_BASE,
	output logic                   IO_SELECT_A,
	output logic                   IO_SELECT_B,
	output logic                   PROGRAM_SELECT,
	output logic                   GENERAL_SELECT,
	output logic      [3:0]        SELECT_PIN_OWNED,
	output logic                   STRETCH_HOLD,
	output logic      [1:0]        ACCESS_STRETCH
);
	// Decode and field layout assume an 8-bit, 64K machine
	if (ADDR_W != 16 || DATA_W != 8) begin : g_bad_width
		$error("ecsu_top supports only ADDR_W 16 and DATA_W 8");
	end

	// Whole state of the block in one record
	typedef struct packed {
		logic [7:0]           stretch;   // Stretch register
		logic [7:0]           ctl;       // Control register
		logic [7:0]           gp_base;   // General base register
		logic [7:0]           gp_size;   // Size and timing register
		logic [7:0]           rdata;     // Read data, one cycle
		logic                 init_done; // Mode defaults applied
		ecsu_pkg::ecsu_state_t fsm;      // Stretch sequencer
		logic [1:0]           cnt;       // Stretch cycles left
		logic [1:0]           acc_st;    // Stretch of this access
		logic [3:0]           hits;      // Hits latched this access
		logic                 sel_a;     // Pin level, first I/O
		logic                 sel_b;     // Pin level, second I/O
		logic                 sel_p;     // Pin level, program
		logic                 sel_g;     // Pin level, general
		logic [3:0]           owned;     // Pin given to a select
	} ecsu_regs_t;

	ecsu_regs_t r;      // Registered state
	ecsu_regs_t next_r; // Next state

	ecsu_cfg_if cfg (); // Settings to decoder, hits back

	// Decoder sees registered settings; address and page nibble come straight from inputs
	assign cfg.addr     = CPU_ADDR;
	assign cfg.base_nib = REG_BLOCK_BASE;
	assign cfg.ctl      = r.ctl;
	assign cfg.gp_size  = r.gp_size;
	assign cfg.gp_base  = r.gp_base;

	ecsu_decode u_decode (
		.cfg (cfg)
	);

	// Stretch field of the first hit select: first I/O, second I/O, program, general
	function automatic logic [1:0] pick_stretch(input logic [7:0] st,
		input logic [3:0] h);
		logic [1:0] v;
		v = 2'h0;
		if (h[0])      v = st[ecsu_pkg::ST_IOA +: 2];
		else if (h[1]) v = st[ecsu_pkg::ST_IOB +: 2];
		else if (h[2]) v = st[ecsu_pkg::ST_PROG +: 2];
		else if (h[3]) v = st[ecsu_pkg::ST_GP +: 2];
		return v;
	endfunction : pick_stretch

	// Drive level for a select given activity and polarity
	function automatic logic drive_level(input logic act,
		input logic act_high);
		return act_high ? act : !act;
	endfunction : drive_level

	logic [3:0] hit_now;    // Live hits from the decoder
	logic       e_phase;    // E high, or held high by stretch
	logic       act_a;      // First I/O active this cycle
	logic       act_b;      // Second I/O active this cycle
	logic       act_p;      // Program active this cycle
	logic       act_g;      // General active this cycle
	logic       write_hit;  // Register write this cycle
	logic [7:0] status;     // Live status byte

	assign hit_now = {cfg.hit_g, cfg.hit_p, cfg.hit_b, cfg.hit_a};

	// Next-state logic for registers, sequencer and pins
	always_comb begin
		next_r = r;
		write_hit = REG_WR && r.init_done;
		e_phase = E_HIGH || (r.fsm == ecsu_pkg::ECSU_STRETCH);

		// Mode defaults caught once, the cycle after reset release
		if (!r.init_done) begin
			next_r.init_done = 1'b1;
			if (EXPANDED_MODE) begin
				next_r.ctl = ecsu_pkg::CTL_EXP; // [R10]
				next_r.stretch = ecsu_pkg::STRETCH_EXP; // [R12]
			end
		end

		// Register writes; reserved bits stay zero
		if (write_hit) begin
			unique case (REG_ADDR)
				ecsu_pkg::OFS_STRETCH: begin
					next_r.stretch = REG_WDATA; // [R14]
				end
				ecsu_pkg::OFS_CTL: begin
					next_r.ctl = REG_WDATA; // [R08] [R10] [R13]
				end
				ecsu_pkg::OFS_GP_BASE: begin
					next_r.gp_base = REG_WDATA &
						ecsu_pkg::GP_BASE_MASK; // [R16]
				end
				ecsu_pkg::OFS_GP_SIZE: begin
					next_r.gp_size = REG_WDATA &
						ecsu_pkg::GP_SIZE_MASK; // [R05]
				end
				default: begin
					// Unmapped write is dropped
				end
			endcase
		end

		// Status: latched hits, sequencer, mode
		status = {2'h0, (r.fsm == ecsu_pkg::ECSU_STRETCH),
			EXPANDED_MODE, r.hits};

		// Read data stands only in the cycle after the strobe
		next_r.rdata = 8'h00;
		if (REG_RD) begin
			unique case (REG_ADDR)
				ecsu_pkg::OFS_STRETCH: next_r.rdata = r.stretch;
				ecsu_pkg::OFS_CTL:     next_r.rdata = r.ctl;
				ecsu_pkg::OFS_GP_BASE: next_r.rdata = r.gp_base;
				ecsu_pkg::OFS_GP_SIZE: next_r.rdata = r.gp_size;
				ecsu_pkg::OFS_STATUS:  next_r.rdata = status;
				default:               next_r.rdata = 8'h00;
			endcase
		end

		// Stretch sequencer, one run per CPU access
		unique case (r.fsm)
			ecsu_pkg::ECSU_IDLE: begin
				// Latch winner's stretch when a select hits [R18]
				if (ADDR_VALID && (hit_now != 4'h0)) begin
					next_r.hits = hit_now;
					next_r.acc_st = pick_stretch(r.stretch,
						hit_now); // [R14]
					next_r.cnt = pick_stretch(r.stretch, hit_now);
					next_r.fsm = ecsu_pkg::ECSU_ACCESS;
				end else begin
					next_r.hits = 4'h0;
					next_r.acc_st = 2'h0;
				end
			end
			ecsu_pkg::ECSU_ACCESS: begin
				// End of the normal E-high phase
				if (!ADDR_VALID) begin
					next_r.fsm = ecsu_pkg::ECSU_IDLE;
				end else if (E_TICK) begin
					if (r.cnt != 2'h0) begin
						next_r.fsm = ecsu_pkg::ECSU_STRETCH; // [R17]
					end else begin
						next_r.fsm = ecsu_pkg::ECSU_DONE;
					end
				end
			end
			ecsu_pkg::ECSU_STRETCH: begin
				// Each tick consumes one extra E clock [R14] [R17]
				if (!ADDR_VALID) begin
					next_r.fsm = ecsu_pkg::ECSU_IDLE;
				end else if (E_TICK) begin
					next_r.cnt = r.cnt - 2'h1;
					if (r.cnt == 2'h1) begin
						next_r.fsm = ecsu_pkg::ECSU_DONE;
					end
				end
			end
			ecsu_pkg::ECSU_DONE: begin
				// Wait for the address to go away
				if (!ADDR_VALID) begin
					next_r.fsm = ecsu_pkg::ECSU_IDLE;
				end
			end
			default: begin
				// Illegal code recovers to idle
				next_r.fsm = ecsu_pkg::ECSU_IDLE;
			end
		endcase

		// Activity with each I/O and general select's timing choice; program on address-valid only
		act_a = ADDR_VALID && cfg.hit_a &&
			(r.gp_size[ecsu_pkg::SZ_IOA_TIM] || e_phase); // [R01]
		act_b = ADDR_VALID && cfg.hit_b &&
			(r.gp_size[ecsu_pkg::SZ_IOB_TIM] || e_phase); // [R02]
		act_p = ADDR_VALID && cfg.hit_p; // [R15]
		act_g = ADDR_VALID && cfg.hit_g &&
			(r.gp_size[ecsu_pkg::SZ_GP_TIM] || e_phase); // [R04]

		// Pin levels; a disabled select holds its idle level [R19]
		next_r.sel_a = drive_level(act_a,
			r.ctl[ecsu_pkg::CTL_IOA_POL]); // [R09]
		next_r.sel_b = drive_level(act_b,
			r.ctl[ecsu_pkg::CTL_IOB_POL]); // [R09]
		next_r.sel_p = drive_level(act_p, 1'b0); // [R15]
		next_r.sel_g = drive_level(act_g,
			r.gp_size[ecsu_pkg::SZ_GP_POL]); // [R03]

		// Pin ownership follows the enables [R19]
		next_r.owned = {
			(r.gp_size[ecsu_pkg::SZ_GP_HI:ecsu_pkg::SZ_GP_LO] !=
				ecsu_pkg::GP_SIZE_OFF), // [R06]
			r.ctl[ecsu_pkg::CTL_PROG_EN],
			r.ctl[ecsu_pkg::CTL_IOB_EN],
			r.ctl[ecsu_pkg::CTL_IOA_EN]};
	end

	// State register; clock enable freezes everything
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			r.stretch   <= ecsu_pkg::STRETCH_RST;
			r.ctl       <= ecsu_pkg::CTL_RST; // [R08]
			r.gp_base   <= ecsu_pkg::GP_BASE_RST;
			r.gp_size   <= ecsu_pkg::GP_SIZE_RST; // [R06]
			r.rdata     <= 8'h00;
			r.init_done <= 1'b0;
			r.fsm       <= ecsu_pkg::ECSU_IDLE;
			r.cnt       <= 2'h0;
			r.acc_st    <= 2'h0;
			r.hits      <= 4'h0;
			// Idle levels for reset polarities
			r.sel_a     <= 1'b1;
			r.sel_b     <= 1'b1;
			r.sel_p     <= 1'b1;
			r.sel_g     <= 1'b1;
			r.owned     <= 4'h0;
		end else if (CE) begin
			r <= next_r;
		end
	end

	// Outputs straight from flip-flops, STRETCH_HOLD decoded from the sequencer state
	assign REG_RDATA        = r.rdata;
	assign IO_SELECT_A      = r.sel_a;
	assign IO_SELECT_B      = r.sel_b;
	assign PROGRAM_SELECT   = r.sel_p;
	assign GENERAL_SELECT   = r.sel_g;
	assign SELECT_PIN_OWNED = r.owned;
	// Asks the E generator to hold E high; the device must cope [R20]
	assign STRETCH_HOLD     = (r.fsm == ecsu_pkg::ECSU_STRETCH);
	assign ACCESS_STRETCH   = r.acc_st;
endmodule : ecsu_top

// ===== testbench.sv
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin bad_count++; \
	$display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, g, e); end end
module testbench;
	logic        clk = 1'b0, rst_n = 1'b0, ce = 1'b1; // Clock, reset
	logic        mode = 1'b0, wr = 1'b0, rd = 1'b0;   // Strap, strobes
	logic        av = 1'b0, eh = 1'b0, et = 1'b0;     // Bus timing
	logic [15:0] ra = 16'h0000, ca = 16'h0000;        // Addresses
	logic [7:0]  wd = 8'h00, rdat, ctl, sz, gb, er;   // Data, shadows
	logic [3:0]  pg = 4'h1, own, ep;                  // Page, owned
	logic        sa, sb, sp, sg, hold, xe;            // Pins
	logic [1:0]  ast;                                 // Winner stretch
	logic [15:0] r = 16'h0026, q;                     // Random state
	logic        rd_d = 1'b0, pk = 1'b0, pk_d = 1'b0, hd = 1'b0;
	logic [2:0]  n = 3'h0, es;                        // Tick count
	logic [7:0]  rq[$];                               // Read notes
	logic [3:0]  pq[$];                               // Pin notes
	logic [2:0]  sq[$];                               // Stretch notes
	logic [15:0] tgt[4] = '{16'h1100, 16'h1900, 16'h4000, 16'h8000};
	logic [11:0] bnd[5] = '{12'h05F, 12'h060, 12'h7FF, 12'h800, 12'hFFF};
	int          compares = 0, bad_count = 0;
	always #2.5 clk = ~clk;
	ecsu_top dut (.CLK(clk), .RST_N(rst_n), .CE(ce), .EXPANDED_MODE(mode),
		.REG_ADDR(ra), .REG_WDATA(wd), .REG_WR(wr), .REG_RD(rd),
		.REG_RDATA(rdat), .CPU_ADDR(ca), .ADDR_VALID(av), .E_HIGH(eh),
		.E_TICK(et), .REG_BLOCK_BASE(pg), .IO_SELECT_A(sa),
		.IO_SELECT_B(sb), .PROGRAM_SELECT(sp), .GENERAL_SELECT(sg),
		.SELECT_PIN_OWNED(own), .STRETCH_HOLD(hold), .ACCESS_STRETCH(ast));
	ecsu_ext_dev u_mem (.sel_n(sp), .clk(clk), .hold(hold), .early(xe));
	// Sixteen steps per call so successive words are unrelated
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		for (int k = 0; k < 16; k++)
			s = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
		return s;
	endfunction : lfsr
	// Expected pins {gen, prog, B, A} from the shadow settings
	function automatic logic [3:0] ref_pins(input logic [15:0] a,
		input logic e);
		logic ha, hb, hp, hg;
		ha = ctl[7] && a[15:12] == pg && !a[11] && a[11:0] >= 12'h060;
		hb = ctl[5] && a[15:12] == pg && a[11];
		hp = ctl[2] && (a[15:13] | (3'h7 >> ctl[1:0])) == 3'h7;
		hg = sz[2:0] != 3'h7
			&& ((a[15:10] ^ gb[7:2]) & ~(6'h3F >> sz[2:0])) == 6'h00;
		if (hp && hg) begin // Overlap settled by priority
			hp = !ctl[3];
			hg = ctl[3];
		end
		ha = ha && (sz[7] || e);
		hb = hb && (sz[6] || e);
		hg = hg && (sz[3] || e);
		return {hg ~^ sz[4], !hp, hb ~^ ctl[4], ha ~^ ctl[6]};
	endfunction : ref_pins
	// Oldest note is compared whenever its result shows
	always @(posedge clk) begin
		rd_d <= rd;
		pk_d <= pk;
		hd <= hold;
		if (hold && et) n <= n + 3'h1;
		if (rd_d) begin
			er = rq.pop_front();
			`CHK(rdat, er)
		end
		if (pk_d) begin
			ep = pq.pop_front();
			`CHK({sg, sp, sb, sa}, ep)
		end
		if (hd && !hold) begin
			es = sq.pop_front();
			`CHK(n, es)
			`CHK(ast, es[1:0])
			n <= 3'h0;
		end
	end
	task automatic reset(input logic m);
		rst_n <= 1'b0;
		mode <= m;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
	endtask : reset
	task automatic wreg(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		ra <= a;
		wd <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wreg
	task automatic rreg(input logic [15:0] a, input logic [7:0] e);
		@(posedge clk);
		ra <= a;
		rd <= 1'b1;
		rq.push_back(e);
		@(posedge clk);
		rd <= 1'b0;
	endtask : rreg
	task automatic cfg(input logic [7:0] c, s, b, input logic [3:0] p);
		ctl = c;
		sz = s;
		gb = b;
		pg <= p;
		wreg(16'h105D, c);
		wreg(16'h105F, s);
		wreg(16'h105E, b);
	endtask : cfg
	// Pins noted for the first cycle; an idle cycle follows
	task automatic acc(input logic [15:0] a, input logic e);
		@(posedge clk);
		ca <= a;
		av <= 1'b1;
		eh <= e;
		pk <= 1'b1;
		pq.push_back(ref_pins(a, e));
		@(posedge clk);
		pk <= 1'b0;
		av <= 1'b0;
		ca <= ~a; // Address not held once released
		@(posedge clk);
	endtask : acc
	// Long access with E ticks every third cycle, E held high
	task automatic stretch(input logic [15:0] a, input logic [2:0] c);
		if (c != 3'h0) sq.push_back(c);
		@(posedge clk);
		ca <= a;
		av <= 1'b1;
		eh <= 1'b1;
		for (int k = 0; k < 16; k++) begin
			@(posedge clk);
			et <= (k % 3 == 2);
		end
		av <= 1'b0;
		eh <= 1'b0;
		repeat (3) @(posedge clk);
	endtask : stretch
	task automatic stop_test;
		$display("compares=%0d mismatches=%0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : stop_test
	initial begin
		repeat (100000) @(posedge clk);
		bad_count++;
		stop_test();
	end
	initial begin
		for (int m = 0; m < 2; m++) begin
			reset(m[0]);
			rreg(16'h105F, 8'h07);
			rreg(16'h105D, m ? 8'h04 : 8'h00);
			rreg(16'h105C, m ? 8'h01 : 8'h00);
			rreg(16'h105E, 8'h00);
		end
		// Status: strap high, no hits, sequencer idle
		rreg(16'h105B, 8'h10);
		// Clock enable low drops the write entirely
		@(posedge clk);
		ce <= 1'b0;
		wreg(16'h105E, 8'hFC);
		ce <= 1'b1;
		rreg(16'h105E, 8'h00);
		wreg(16'h105F, 8'hFF);
		wreg(16'h1060, 8'hFF);
		rreg(16'h105F, 8'hDF);
		rreg(16'h1060, 8'h00);
		$display("test registers done");
		for (int i = 0; i < 400; i++) begin
			r = lfsr(r);
			q = lfsr(r);
			cfg(r[7:0], r[15:8], q[7:0], q[11:8]);
			r = lfsr(q);
			acc(r[0] ? {pg, r[12:1]} : r, q[12]);
		end
		cfg(8'hF0, 8'h07, 8'h00, 4'h1);
		`CHK(own, 4'h3)
		foreach (bnd[j]) begin
			acc({4'h1, bnd[j]}, 1'b1);
			acc({4'h2, bnd[j]}, 1'b0);
		end
		$display("test select pins done");
		cfg(8'hAC, 8'hCE, 8'h40, 4'h1);
		`CHK(own, 4'hF)
		for (int s = 0; s < 4; s++)
			for (int c = 0; c < 4; c++) begin
				wreg(16'h105C, 8'(c << (6 - 2 * s)));
				stretch(tgt[s], c[2:0]);
			end
		repeat (4) @(posedge clk);
		`CHK(rq.size() + pq.size() + sq.size(), 0)
		`CHK(xe, 1'b0)
		$display("test stretch done");
		stop_test();
	end
endmodule : testbench
